// >>> common/ptm_consts.vh
// constants for the loop test-mode control block
`ifndef PTM_CONSTS_VH
`define PTM_CONSTS_VH

// register byte offsets on the apb window
`define PTM_OFF_CTRL        12'h000
`define PTM_OFF_STATUS      12'h004
`define PTM_OFF_STEPCNT     12'h008

// control register fields
`define PTM_CTRL_PROBE_EN   0
`define PTM_CTRL_SLOW_EN    1
`define PTM_CTRL_RST        32'h0000_0003

// status register fields
`define PTM_ST_MODE         0
`define PTM_ST_STEP_A       1
`define PTM_ST_STEP_B       2
`define PTM_ST_TSEL         3
`define PTM_ST_IDD          4
`define PTM_ST_FB_SEEN      5
`define PTM_ST_BYPASS       6
`define PTM_ST_PROBE_OE     7
`define PTM_ST_PROBE_SEL    8

// analog probe selector codes
`define PTM_PROBE_OFF       2'h0
`define PTM_PROBE_VOLT      2'h1
`define PTM_PROBE_CURR      2'h2

// divider stage counts: 2^n division
`define PTM_DIV_HALF        1
`define PTM_DIV_SLOW        2

// synchroniser depth and clock figures
`define PTM_SYNC_STAGES     2
`define PTM_CLK_PERIOD_NS   25

`endif

// >>> logic/ptm_div.v
// divide a sampled clock level by a power of two
`timescale 1ns/1ps
`default_nettype none

module ptm_div #(
	parameter STAGES = 1
) (
	input  wire clk,
	input  wire rst_n,
	input  wire clear,
	input  wire in_lvl,
	output wire out_lvl
);

	reg              prev_q;
	reg [STAGES-1:0] cnt_q;

	// count rising edges of the sampled clock; msb is the divided clock
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prev_q <= 1'b0;
			cnt_q  <= {STAGES{1'b0}};
		end
		else
		begin
			prev_q <= in_lvl;
			if (clear)
				cnt_q <= {STAGES{1'b0}};
			else if (in_lvl && !prev_q)
				cnt_q <= cnt_q + {{(STAGES-1){1'b0}}, 1'b1};
		end
	end

	assign out_lvl = cnt_q[STAGES-1];

endmodule // ptm_div

`default_nettype wire

// >>> logic/ptm_ctrl.v
// test-mode control around the on-chip analog phase-locked loop
//
// Function
// - both test pins low clears the mode flop and both step flops.
// - in normal mode the loop clock outputs stay low until feedback_in is seen low.
// - test_select high with the mode flop clear powers loop down and bypasses reference onto vco output.
// - in bypass the half output carries reference divided by two.
// - half-rate vco clock divided by four drives slow_test_out.
// - test_select rising with idd_enable high sets the mode flop.
// - in loop test, idd_enable pulses step flops 00,10,01,11.
// - step 00 with idd_enable low leaves the probe pin undriven.
// - step 10 with idd_enable low puts control voltage on probe.
// - step 01 with idd_enable low puts charge pump current on probe.
// - step 11 with idd_enable high keeps loop running for idd.
// - idd_enable high powers down the differential reference buffer.
// - test_select rising with idd_enable low starts core test, flops zero.
// - core test with idd_enable high switches loop bias currents off.
// - both pins low runs the loop normally as system clock.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ptm_consts.vh"

module ptm_ctrl (
	input  wire        MCLK,
	input  wire        RST_N,
	input  wire        TEST_SELECT,
	input  wire        IDD_ENABLE,
	input  wire        REF_CLOCK_IN,
	input  wire        VCO_RAW_IN,
	input  wire        FEEDBACK_IN,
	output reg         VCO_CLOCK_OUT,
	output reg         VCO_HALF_OUT,
	output reg         SLOW_TEST_OUT,
	output reg         LOOP_POWER_DOWN,
	output reg         LOOP_BIAS_OFF,
	output reg         REF_BUF_POWER_DOWN,
	output reg         PROBE_OE,
	output reg  [1:0]  PROBE_SEL,
	output reg         TEST_MODE_FLOP,
	output reg         TEST_STEP_FLOP_A,
	output reg         TEST_STEP_FLOP_B,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [11:0] PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output wire        PREADY,
	output wire        PSLVERR
);

	// pin sampling: bit 0 select, 1 idd, 2 ref, 3 vco, 4 feedback
	localparam NPIN = 5;

	// operating modes, one-hot
	localparam MODE_NORMAL = 4'b0001;
	localparam MODE_BYPASS = 4'b0010;
	localparam MODE_LOOP   = 4'b0100;
	localparam MODE_SETUP  = 4'b1000;

	reg  [NPIN-1:0] sync1_q;
	reg  [NPIN-1:0] sync2_q;
	reg             tsel_prev_q;
	reg             idd_prev_q;
	reg             mode_flop_q;
	reg             mode_flop_d;
	reg             step_a_q;
	reg             step_a_d;
	reg             step_b_q;
	reg             step_b_d;
	reg             fb_seen_q;
	reg  [31:0]     ctrl_q;
	reg  [15:0]     step_cnt_q;
	reg  [3:0]      mode_st;
	reg             bypass_d;
	reg             probe_oe_d;
	reg  [1:0]      probe_sel_d;
	reg             vco_out_d;
	reg             half_out_d;
	reg  [31:0]     rdata_d;
	reg             addr_hit;

	wire            tsel;
	wire            idd;
	wire            ref_lvl;
	wire            vco_lvl;
	wire            fb_lvl;
	wire            tsel_rise;
	wire            idd_rise;
	wire            both_low;
	wire            ref_half;
	wire            vco_half;
	wire            vco_slow;
	wire            wr_en;
	wire            rd_en;

	// two-flop synchronisers for every pin; only stage two is looked at
	always @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sync1_q <= {NPIN{1'b0}};
			sync2_q <= {NPIN{1'b0}};
		end
		else
		begin
			sync1_q <= {FEEDBACK_IN, VCO_RAW_IN, REF_CLOCK_IN, IDD_ENABLE, TEST_SELECT};
			sync2_q <= sync1_q;
		end
	end

	assign tsel    = sync2_q[0];
	assign idd     = sync2_q[1];
	assign ref_lvl = sync2_q[2];
	assign vco_lvl = sync2_q[3];
	assign fb_lvl  = sync2_q[4];

	// edge history taken from the settled samples
	always @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			tsel_prev_q <= 1'b0;
			idd_prev_q  <= 1'b0;
		end
		else
		begin
			tsel_prev_q <= tsel;
			idd_prev_q  <= idd;
		end
	end

	assign tsel_rise = tsel && !tsel_prev_q;
	assign idd_rise  = idd && !idd_prev_q;
	assign both_low  = !tsel && !idd;

	// next state of the three test flops
	always @*
	begin
		mode_flop_d = mode_flop_q;
		step_a_d    = step_a_q;
		step_b_d    = step_b_q;
		if (both_low)
		begin
			mode_flop_d = 1'b0;
			step_a_d    = 1'b0;
			step_b_d    = 1'b0;
		end
		else if (tsel_rise)
		begin
			// idd high enters loop test, idd low leaves the flops clear
			mode_flop_d = idd;
			step_a_d    = 1'b0;
			step_b_d    = 1'b0;
		end
		else if (mode_flop_q && tsel && idd_rise)
		begin
			// a is the low bit: 00, 10, 01, 11, then back round
			step_a_d = !step_a_q;
			step_b_d = step_b_q ^ step_a_q;
		end
	end

	// test flop storage; reset leaves system mode
	always @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			mode_flop_q <= 1'b0;
			step_a_q    <= 1'b0;
			step_b_q    <= 1'b0;
		end
		else
		begin
			mode_flop_q <= mode_flop_d;
			step_a_q    <= step_a_d;
			step_b_q    <= step_b_d;
		end
	end

	// count of step advances, for software to follow the tester
	always @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			step_cnt_q <= 16'h0000;
		else if (both_low)
			step_cnt_q <= 16'h0000;
		else if (mode_flop_q && tsel && idd_rise)
			step_cnt_q <= step_cnt_q + 16'h0001;
	end

	// feedback seen at a low level: loop divider may now be reset
	always @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			fb_seen_q <= 1'b0;
		else if (!fb_lvl)
			fb_seen_q <= 1'b1;
	end

	// decode the operating mode from pins and flops
	always @*
	begin
		if (!tsel && !mode_flop_q)
			mode_st = MODE_NORMAL;
		else if (tsel && !mode_flop_q)
			mode_st = MODE_BYPASS;
		else if (tsel && mode_flop_q)
			mode_st = MODE_LOOP;
		else
			mode_st = MODE_SETUP;
	end

	// dividers: reference by two, vco by two, half-rate by four
	ptm_div #(
		.STAGES (`PTM_DIV_HALF)
	) u_ref_half (
		.clk     (MCLK),
		.rst_n   (RST_N),
		.clear   (both_low),
		.in_lvl  (ref_lvl),
		.out_lvl (ref_half)
	);

	ptm_div #(
		.STAGES (`PTM_DIV_HALF)
	) u_vco_half (
		.clk     (MCLK),
		.rst_n   (RST_N),
		.clear   (1'b0),
		.in_lvl  (vco_lvl),
		.out_lvl (vco_half)
	);

	ptm_div #(
		.STAGES (`PTM_DIV_SLOW)
	) u_vco_slow (
		.clk     (MCLK),
		.rst_n   (RST_N),
		.clear   (!ctrl_q[`PTM_CTRL_SLOW_EN]),
		.in_lvl  (vco_half),
		.out_lvl (vco_slow)
	);

	// clock routing and probe selection per mode
	always @*
	begin
		bypass_d    = 1'b0;
		probe_oe_d  = 1'b0;
		probe_sel_d = `PTM_PROBE_OFF;
		vco_out_d   = 1'b0;
		half_out_d  = 1'b0;
		case (mode_st)
			MODE_NORMAL:
			begin
				// held low until feedback is known, so the divider can reset
				vco_out_d  = fb_seen_q & vco_lvl;
				half_out_d = fb_seen_q & vco_half;
			end
			MODE_BYPASS:
			begin
				bypass_d   = 1'b1;
				vco_out_d  = ref_lvl;
				half_out_d = ref_half;
			end
			MODE_LOOP:
			begin
				vco_out_d  = vco_lvl;
				half_out_d = vco_half;
				if (!idd && ctrl_q[`PTM_CTRL_PROBE_EN])
				begin
					if (step_a_q && !step_b_q)
					begin
						probe_oe_d  = 1'b1;
						probe_sel_d = `PTM_PROBE_VOLT;
					end
					else if (!step_a_q && step_b_q)
					begin
						probe_oe_d  = 1'b1;
						probe_sel_d = `PTM_PROBE_CURR;
					end
				end
			end
			MODE_SETUP:
			begin
				// select dropped with idd still high: loop free, flops kept
				vco_out_d  = vco_lvl;
				half_out_d = vco_half;
			end
			default:
			begin
				bypass_d = 1'b0;
			end
		endcase
	end

	// registered pin outputs; one cycle after the sampled cause
	always @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			VCO_CLOCK_OUT      <= 1'b0;
			VCO_HALF_OUT       <= 1'b0;
			SLOW_TEST_OUT      <= 1'b0;
			LOOP_POWER_DOWN    <= 1'b0;
			LOOP_BIAS_OFF      <= 1'b0;
			REF_BUF_POWER_DOWN <= 1'b0;
			PROBE_OE           <= 1'b0;
			PROBE_SEL          <= `PTM_PROBE_OFF;
			TEST_MODE_FLOP     <= 1'b0;
			TEST_STEP_FLOP_A   <= 1'b0;
			TEST_STEP_FLOP_B   <= 1'b0;
		end
		else
		begin
			VCO_CLOCK_OUT      <= vco_out_d;
			VCO_HALF_OUT       <= half_out_d;
			SLOW_TEST_OUT      <= vco_slow;
			LOOP_POWER_DOWN    <= bypass_d;
			LOOP_BIAS_OFF      <= bypass_d & idd;
			REF_BUF_POWER_DOWN <= idd;
			PROBE_OE           <= probe_oe_d;
			PROBE_SEL          <= probe_sel_d;
			TEST_MODE_FLOP     <= mode_flop_q;
			TEST_STEP_FLOP_A   <= step_a_q;
			TEST_STEP_FLOP_B   <= step_b_q;
		end
	end

	// apb slave: zero wait states, error on unmapped word
	assign wr_en   = PSEL && PENABLE && PWRITE;
	assign rd_en   = PSEL && PENABLE && !PWRITE;
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !addr_hit;

	// read mux; unmapped reads return zero
	always @*
	begin
		addr_hit = 1'b1;
		rdata_d  = 32'h0000_0000;
		case (PADDR)
			`PTM_OFF_CTRL:
				rdata_d = ctrl_q;
			`PTM_OFF_STATUS:
			begin
				rdata_d[`PTM_ST_MODE]      = mode_flop_q;
				rdata_d[`PTM_ST_STEP_A]    = step_a_q;
				rdata_d[`PTM_ST_STEP_B]    = step_b_q;
				rdata_d[`PTM_ST_TSEL]      = tsel;
				rdata_d[`PTM_ST_IDD]       = idd;
				rdata_d[`PTM_ST_FB_SEEN]   = fb_seen_q;
				rdata_d[`PTM_ST_BYPASS]    = LOOP_POWER_DOWN;
				rdata_d[`PTM_ST_PROBE_OE]  = PROBE_OE;
				rdata_d[`PTM_ST_PROBE_SEL+1:`PTM_ST_PROBE_SEL] = PROBE_SEL;
			end
			`PTM_OFF_STEPCNT:
				rdata_d = {16'h0000, step_cnt_q};
			default:
				addr_hit = 1'b0;
		endcase
	end

	// control write at the access edge, read data capture at the setup edge
	always @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ctrl_q <= `PTM_CTRL_RST;
			PRDATA <= 32'h0000_0000;
		end
		else
		begin
			// only the two defined bits store; the rest read as zero
			if (wr_en && PADDR == `PTM_OFF_CTRL)
				ctrl_q <= PWDATA & `PTM_CTRL_RST;
			if (PSEL && !PENABLE && !PWRITE)
				PRDATA <= rdata_d;
			else if (rd_en)
				PRDATA <= PRDATA;
			else
				PRDATA <= 32'h0000_0000;
		end
	end

endmodule // ptm_ctrl

`default_nettype wire

// >>> verif/ptm_chk.sv
// assertion checker on the test-mode control ports
`timescale 1ns/1ps
`default_nettype none
`include "ptm_consts.vh"

module ptm_chk (
	input wire logic       MCLK,
	input wire logic       RST_N,
	input wire logic       TEST_SELECT,
	input wire logic       IDD_ENABLE,
	input wire logic       LOOP_POWER_DOWN,
	input wire logic       LOOP_BIAS_OFF,
	input wire logic       REF_BUF_POWER_DOWN,
	input wire logic       PROBE_OE,
	input wire logic [1:0] PROBE_SEL,
	input wire logic       TEST_MODE_FLOP,
	input wire logic       TEST_STEP_FLOP_A,
	input wire logic       TEST_STEP_FLOP_B
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	// pins need six steady samples to cross synchroniser, state and output flops
	clear_flops_a: assert property (
		(!TEST_SELECT && !IDD_ENABLE)[*6] |->
		{TEST_MODE_FLOP, TEST_STEP_FLOP_A, TEST_STEP_FLOP_B} == 3'h0) else $error("flops kept");
	normal_run_a: assert property (
		(!TEST_SELECT && !IDD_ENABLE)[*6] |-> !LOOP_POWER_DOWN && !LOOP_BIAS_OFF)
		else $error("loop not running");
	mode_set_a: assert property (
		$rose(TEST_MODE_FLOP) |-> TEST_SELECT && IDD_ENABLE && !TEST_STEP_FLOP_A
		&& !TEST_STEP_FLOP_B) else $error("bad mode entry");
	// step code {b,a} counts up by one, so the walk 00,10,01,11 is a plain increment
	step_walk_a: assert property (
		$changed({TEST_STEP_FLOP_B, TEST_STEP_FLOP_A}) && TEST_MODE_FLOP |->
		{TEST_STEP_FLOP_B, TEST_STEP_FLOP_A} == $past({TEST_STEP_FLOP_B, TEST_STEP_FLOP_A}) + 2'h1)
		else $error("step order");
	step_hold_a: assert property (
		$changed({TEST_STEP_FLOP_B, TEST_STEP_FLOP_A}) |-> $past(TEST_MODE_FLOP)
		|| {TEST_STEP_FLOP_B, TEST_STEP_FLOP_A} == 2'h0) else $error("step outside mode");
	probe_off_a: assert property (
		(TEST_MODE_FLOP && !TEST_STEP_FLOP_A && !TEST_STEP_FLOP_B && !IDD_ENABLE)[*6]
		|-> !PROBE_OE) else $error("probe driven");
	probe_volt_a: assert property (
		(TEST_MODE_FLOP && TEST_STEP_FLOP_A && !TEST_STEP_FLOP_B && !IDD_ENABLE)[*6]
		|-> PROBE_OE && PROBE_SEL == `PTM_PROBE_VOLT) else $error("no voltage probe");
	probe_curr_a: assert property (
		(TEST_MODE_FLOP && !TEST_STEP_FLOP_A && TEST_STEP_FLOP_B && !IDD_ENABLE)[*6]
		|-> PROBE_OE && PROBE_SEL == `PTM_PROBE_CURR) else $error("no current probe");
	ref_buf_a: assert property (
		$stable(IDD_ENABLE)[*6] |-> REF_BUF_POWER_DOWN == IDD_ENABLE)
		else $error("ref buffer power");
	bypass_bias_a: assert property (
		(TEST_SELECT && !TEST_MODE_FLOP && $stable(IDD_ENABLE))[*7] |->
		LOOP_POWER_DOWN && LOOP_BIAS_OFF == IDD_ENABLE) else $error("core test power");
endmodule // ptm_chk

bind ptm_ctrl ptm_chk chk_u (.MCLK, .RST_N, .TEST_SELECT, .IDD_ENABLE, .LOOP_POWER_DOWN,
	.LOOP_BIAS_OFF, .REF_BUF_POWER_DOWN, .PROBE_OE, .PROBE_SEL, .TEST_MODE_FLOP,
	.TEST_STEP_FLOP_A, .TEST_STEP_FLOP_B);
`default_nettype wire

// >>> verif/ptm_tester.sv
// production tester model driving the test pins and the two clocks
`timescale 1ns/1ps
`default_nettype none

module ptm_tester (
	input  wire logic clk,
	output var  logic tsel,
	output var  logic idd,
	output var  logic ref_clk,
	output var  logic vco_raw,
	output var  logic fb
);
	logic [1:0] cnt_q;

	// start-up levels: select low first so the flops initialise
	initial
	begin
		tsel = 1'b0;
		idd = 1'b0;
		ref_clk = 1'b0;
		vco_raw = 1'b0;
		fb = 1'b0; // known level, no divider reset is ever pulsed
		cnt_q = 2'h0;
	end

	// clocks toggle every fourth edge, well below a quarter of the sampling rate
	always @(posedge clk)
	begin
		cnt_q <= cnt_q + 2'h1;
		if (cnt_q == 2'h3)
		begin
			vco_raw <= ~vco_raw;
			ref_clk <= tsel & ~ref_clk; // low until select rises
		end
	end

	// dwell after each change so sync, step and any relock settle
	task automatic pins(input logic s, input logic e);
		@(posedge clk);
		tsel <= s;
		idd <= e;
		repeat (10) @(posedge clk);
	endtask
endmodule // ptm_tester
`default_nettype wire

// >>> verif/pll_test_mode_control_test.sv
// self-checking bench for the loop test-mode control block
`timescale 1ns/1ps
`default_nettype none
`include "ptm_consts.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
	$display("ERROR %0t value mismatch", $time); end end

module pll_test_mode_control_test;
	logic        mclk, rst_n, psel, penable, pwrite, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	logic [1:0]  stp [4];
	logic [2:0]  prb [4];
	wire logic   tsel, idd, ref_clk, vco_raw, fb, vco_o, half_o, slow_o, lpd, bias, rbuf;
	wire logic   poe, tm, sa, sb, pready, pslverr;
	wire logic [1:0]  psel2;
	wire logic [31:0] prdata;
	wire logic [2:0]  mon = {slow_o, half_o, vco_o};
	int          failures, num_checks, p, k;

	ptm_ctrl dut_u (.MCLK(mclk), .RST_N(rst_n), .TEST_SELECT(tsel), .IDD_ENABLE(idd),
		.REF_CLOCK_IN(ref_clk), .VCO_RAW_IN(vco_raw), .FEEDBACK_IN(fb),
		.VCO_CLOCK_OUT(vco_o), .VCO_HALF_OUT(half_o), .SLOW_TEST_OUT(slow_o),
		.LOOP_POWER_DOWN(lpd), .LOOP_BIAS_OFF(bias), .REF_BUF_POWER_DOWN(rbuf),
		.PROBE_OE(poe), .PROBE_SEL(psel2), .TEST_MODE_FLOP(tm), .TEST_STEP_FLOP_A(sa),
		.TEST_STEP_FLOP_B(sb), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr));
	ptm_tester tst_u (.clk(mclk), .tsel(tsel), .idd(idd), .ref_clk(ref_clk),
		.vco_raw(vco_raw), .fb(fb));

	// free-running system clock
	always #12.5 mclk = ~mclk;

	task automatic wrap_up();
		if (failures == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// one apb transfer; the answer is taken only at the edge with pready high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		for (n = 0; pready !== 1'b1; n++)
		begin
			if (n == 20)
			begin
				failures++;
				wrap_up();
			end
			@(posedge mclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// cycles between two rising edges of a monitored clock output, -1 if none
	task automatic per(input int i, output int q);
		int n, t0;
		logic l;
		t0 = -1;
		q = -1;
		l = mon[i];
		for (n = 0; n < 300 && q < 0; n++)
		begin
			@(posedge mclk);
			if (mon[i] === 1'b1 && l === 1'b0)
			begin
				if (t0 < 0)
					t0 = n;
				else
					q = n - t0;
			end
			l = mon[i];
		end
	endtask

	initial
	begin
		mclk = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		failures = 0;
		num_checks = 0;
		stp = '{2'h2, 2'h1, 2'h3, 2'h0};
		prb = '{3'h5, 3'h6, 3'h0, 3'h0};
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		// register window: reset value, write mask, unmapped slot
		apb(1'b0, `PTM_OFF_CTRL, 32'h0000_0000);
		`CHK(rd, `PTM_CTRL_RST)
		apb(1'b1, `PTM_OFF_CTRL, 32'hFFFF_FFFF);
		apb(1'b0, `PTM_OFF_CTRL, 32'h0000_0000);
		`CHK(rd, 32'h0000_0003)
		apb(1'b0, 12'h00C, 32'h0000_0000);
		`CHK({err, rd}, {1'b1, 32'h0000_0000})
		// normal use: pins low keep flops clear and the loop powered
		tst_u.pins(1'b0, 1'b0);
		`CHK({tm, sa, sb, lpd}, 4'h0)
		// feedback is held known, so the loop clocks follow the vco
		per(0, p);
		`CHK(p, 8)
		per(1, p);
		`CHK(p, 16)
		// setup then select: loop test with the probe off at step 00
		tst_u.pins(1'b0, 1'b1);
		tst_u.pins(1'b1, 1'b1);
		`CHK({tm, sa, sb}, 3'h4)
		tst_u.pins(1'b1, 1'b0);
		`CHK({poe, lpd}, 2'h0)
		per(2, p);
		`CHK(p, 64)
		apb(1'b0, `PTM_OFF_STATUS, 32'h0000_0000);
		`CHK(rd, 32'h0000_0029)
		// each enable pulse walks the steps, and the probe follows at enable low
		for (k = 0; k < 4; k++)
		begin
			tst_u.pins(1'b1, 1'b1);
			`CHK({sa, sb, rbuf, lpd}, {stp[k], 2'h2})
			tst_u.pins(1'b1, 1'b0);
			if (k != 2)
				`CHK({poe, psel2}, prb[k])
		end
		// four pulses counted; slow output stops once its enable is cleared
		apb(1'b0, `PTM_OFF_STEPCNT, 32'h0000_0000);
		`CHK(rd, 32'h0000_0004)
		apb(1'b1, `PTM_OFF_CTRL, 32'h0000_0000);
		per(2, p);
		`CHK(p, -1)
		tst_u.pins(1'b0, 1'b0);
		`CHK({tm, sa, sb, lpd}, 4'h0)
		// core test: bypass, reference and its half on the loop outputs
		tst_u.pins(1'b1, 1'b0);
		`CHK({tm, sa, sb, lpd}, 4'h1)
		per(0, p);
		`CHK(p, 8)
		per(1, p);
		`CHK(p, 16)
		tst_u.pins(1'b1, 1'b1);
		`CHK({tm, sa, sb, bias, rbuf}, 5'h03)
		tst_u.pins(1'b1, 1'b0);
		`CHK(bias, 1'b0)
		wrap_up();
	end
endmodule // pll_test_mode_control_test
`default_nettype wire
